// ==== tmr_defines.vh ====
// Constants for the 16-bit timer control block: register offsets, field
// positions, reset values and mode codes. Included by tmr_timer16.v.
`ifndef TMR_DEFINES_VH
`define TMR_DEFINES_VH

// Register offsets on the plain register port
`define TMR_OFS_CTRL1 4'h0
`define TMR_OFS_CTRL2 4'h1
`define TMR_OFS_FLAGS 4'h2
`define TMR_OFS_CAP1H 4'h3
`define TMR_OFS_CAP1L 4'h4
`define TMR_OFS_CMP1H 4'h5
`define TMR_OFS_CMP1L 4'h6
`define TMR_OFS_CMP2H 4'h7
`define TMR_OFS_CMP2L 4'h8
`define TMR_OFS_CNTH 4'h9
`define TMR_OFS_CNTL 4'ha
`define TMR_OFS_CAP2H 4'hb
`define TMR_OFS_CAP2L 4'hc

// Control one fields
`define TMR_C1_CAP_IE 7
`define TMR_C1_CMP_IE 6
`define TMR_C1_OVF_IE 5
`define TMR_C1_FORCE2 4
`define TMR_C1_FORCE1 3
`define TMR_C1_LEVEL2 2
`define TMR_C1_EDGE1 1
`define TMR_C1_LEVEL1 0

// Control two fields
`define TMR_C2_PIN1_EN 7
`define TMR_C2_PIN2_EN 6
`define TMR_C2_ONE_PULSE 5
`define TMR_C2_PWM 4
`define TMR_C2_CLK_HI 3
`define TMR_C2_CLK_LO 2
`define TMR_C2_EDGE2 1
`define TMR_C2_EXT_EDGE 0

// Flag register fields
`define TMR_F_CAP1 7
`define TMR_F_CMP1 6
`define TMR_F_OVF 5
`define TMR_F_CAP2 4
`define TMR_F_CMP2 3

// Reset values
`define TMR_CTRL_RST 8'h00
`define TMR_CNT_RST 16'hfffc
`define TMR_CMP_RST 16'h8000

// Clock select codes
`define TMR_CLK_DIV4 2'h0
`define TMR_CLK_DIV2 2'h1
`define TMR_CLK_DIV8 2'h2
`define TMR_CLK_EXT 2'h3

`endif

// ==== tmr_pin_model.sv ====
// Pin-side partner: external clock source and the two capture inputs.
// Runs on clk_sys; every pin changes just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model (
  input wire logic clk_sys,
  input wire logic extRun,
  input wire logic capLevelOne,
  input wire logic capLevelTwo,
  output logic externalClockPin,
  output logic capturePinOne,
  output logic capturePinTwo
);
  logic [1:0] phase_q;
  initial begin
    phase_q = 2'h0;
    externalClockPin = 1'b0;
    capturePinOne = 1'b0;
    capturePinTwo = 1'b0;
  end
  // Clock toggles every four cycles while running, parks low otherwise
  always @(posedge clk_sys) begin
    phase_q <= extRun ? phase_q + 2'h1 : 2'h0;
    if (!extRun) externalClockPin <= 1'b0;
    else if (phase_q == 2'h3) externalClockPin <= !externalClockPin;
    capturePinOne <= capLevelOne;
    capturePinTwo <= capLevelTwo;
  end
endmodule // tmr_pin_model
`default_nettype wire

// ==== tmr_timer16.v ====
// 16-bit free-running timer: control registers, counter, capture, compare,
// one-pulse and PWM output, interrupt request and low-power behaviour.
// Assumes a CPU-side register port on clk_sys and asynchronous pin inputs.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`include "tmr_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module tmr_timer16 #(
  parameter ADDR_W = 4
) (
  input wire clk_sys,
  input wire reset,
  input wire [ADDR_W-1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  input wire globalIrqMask,
  input wire idleMode,
  input wire deepStop,
  input wire capturePinOne,
  input wire capturePinTwo,
  input wire externalClockPin,
  output reg timerIrq,
  output reg wakeIdle,
  output reg comparePinOne,
  output reg comparePinOneEn,
  output reg comparePinTwo,
  output reg comparePinTwoEn
);

  // Register map on the plain port
  // Offset 0: control one, interrupt enables and output levels
  // Offset 1: control two, pin enables, modes, clock select
  // Offset 2: flag byte, read only, low three bits read zero
  // Offsets 3 and 4: capture one value, high then low byte
  // Offsets 5 and 6: compare one value, high then low byte
  // Offsets 7 and 8: compare two value, high then low byte
  // Offsets 9 and a: counter, high then low byte
  // Offsets b and c: capture two value, high then low byte
  // Other offsets read zero and ignore writes
  //
  // Read timing
  // Read data registered, valid one cycle after the strobe
  // Outside that cycle the read port idles at zero
  // Counter bytes read live; no high-byte latch here
  // Software reading both bytes must allow for a carry between them
  //
  // Write timing
  // Writes land on the strobe edge, visible next cycle
  // Compare high write disarms that compare
  // Compare low write re-arms it and completes the value
  // Hazard: a half-written compare value never matches
  // Counter low write restarts the count from its reset value
  // Counter high write ignored; the counter is read only otherwise
  //
  // Flag clearing
  // Step one: any read of the flag byte arms clearing
  // Arming stays set once taken; it is not cleared again
  // Step two: read or write of the matching low byte clears
  // Capture one low clears capture one flag
  // Compare one low clears compare one flag
  // Counter low clears the overflow flag
  // Capture two low clears capture two flag
  // Compare two low clears compare two flag
  // A new event in the clearing cycle keeps its flag set
  //
  // Timer clock
  // Three-bit prescaler runs free from reset
  // Divide by two, four or eight picked by clock select
  // External pin edges counted when clock select is 11
  // Edge polarity of the external pin from its select bit
  // External pin must stay low and high for two cycles each
  // Faster external clocks lose edges in the synchroniser
  //
  // Pin inputs
  // All three pins cross two flip-flops before use
  // A third history flop gives the previous level for edges
  // Pin edges reach the logic two cycles after the pin moves
  // Pulses shorter than one clock cycle may be missed
  //
  // Compare matches
  // A match needs a tick, an armed compare and equal count
  // Matches are therefore seen once per counter value
  // In plain compare mode level one goes to pin one
  // and level two goes to pin two on their matches
  // In plain compare mode force bits copy the levels every cycle while set
  //
  // One-pulse mode
  // Selected capture one edge restarts the counter
  // Pin one takes level two at the start of the pulse
  // Capture one value loads the count after the reset value
  // Capture one flag sets to mark the start
  // Compare one match returns pin one to level one
  // Compare one flag never sets in this mode
  //
  // Pulse width mode
  // Compare two match restarts the counter each period
  // Pin one takes level two at each period start
  // Compare one match returns pin one to level one
  // Capture one flag marks every period start
  // Neither compare flag sets in this mode
  // Capture one pin is ignored; capture two still works
  // Pulse width wins when both modes are selected
  //
  // Low power
  // Idle: timer runs on, enabled flags raise the wake line
  // Deep stop: counter and prescaled ticks frozen
  // Deep stop: no wake from any timer event
  // Deep stop: capture edges arm their capture
  // Leaving deep stop: armed captures load the count
  // and set their flags in the same cycle
  // Reset from deep stop restarts the count as usual
  //
  // Interrupt request
  // One request line shared by all five events
  // Capture enable covers both capture flags
  // Compare enable covers both compare flags
  // Overflow enable covers the overflow flag
  // Global mask high holds the request low
  // Request follows flags by one cycle

  reg [7:0] ctrlOne_q;
  reg [7:0] ctrlTwo_q;
  reg [4:0] flags_q;
  reg [15:0] count_q;
  reg [15:0] cap1_q;
  reg [15:0] cap2_q;
  reg [15:0] cmp1_q;
  reg [15:0] cmp2_q;
  reg cmp1Armed_q;
  reg cmp2Armed_q;
  reg flagsRead_q;
  reg [2:0] prescale_q;
  reg [2:0] cap1Sync_q;
  reg [2:0] cap2Sync_q;
  reg [2:0] extSync_q;
  reg arm1_q;
  reg arm2_q;
  reg stopped_q;
  reg pulseOut_q;
  reg pin2Out_q;

  // Edge test on a synchronised pin history
  function edgeSeen;
    input prev;
    input cur;
    input rising;
    begin
      edgeSeen = rising ? (~prev & cur) : (prev & ~cur);
    end
  endfunction

  wire pwmMode = ctrlTwo_q[`TMR_C2_PWM];
  wire onePulse = ctrlTwo_q[`TMR_C2_ONE_PULSE] & ~pwmMode;
  wire [1:0] clkSel = ctrlTwo_q[`TMR_C2_CLK_HI:`TMR_C2_CLK_LO];
  wire wrCtrl = regWrite;
  wire cap1Edge = edgeSeen(cap1Sync_q[2], cap1Sync_q[1], ctrlOne_q[`TMR_C1_EDGE1]);
  wire cap2Edge = edgeSeen(cap2Sync_q[2], cap2Sync_q[1], ctrlTwo_q[`TMR_C2_EDGE2]);
  wire extEdge = edgeSeen(extSync_q[2], extSync_q[1], ctrlTwo_q[`TMR_C2_EXT_EDGE]);

  // Timer tick from prescaler or external pin
  reg tick;
  always @* begin
    case (clkSel)
      `TMR_CLK_DIV4: tick = (prescale_q[1:0] == 2'h3);
      `TMR_CLK_DIV2: tick = prescale_q[0];
      `TMR_CLK_DIV8: tick = (prescale_q == 3'h7);
      default: tick = extEdge;
    endcase
  end

  // Frozen in deep stop; idle has no effect
  wire run = tick & ~deepStop;
  wire waking = stopped_q & ~deepStop;
  wire match1 = run & cmp1Armed_q & (count_q == cmp1_q);
  wire match2 = run & cmp2Armed_q & (count_q == cmp2_q);
  wire pwmPeriod = pwmMode & match2;
  wire pulseStart = onePulse & cap1Edge & ~deepStop;
  wire cap1Now = (~pwmMode & ~onePulse & cap1Edge & ~deepStop) | (waking & arm1_q);
  wire cap2Now = (cap2Edge & ~deepStop) | (waking & arm2_q);
  wire overflow = run & (count_q == 16'hffff) & ~pwmPeriod;
  wire [3:0] ofs = regAddr[3:0];
  wire rdAny = regRead | regWrite;

  // Input synchronisers, pin history bits
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cap1Sync_q <= 3'h0;
      cap2Sync_q <= 3'h0;
      extSync_q <= 3'h0;
      prescale_q <= 3'h0;
    end else begin
      cap1Sync_q <= {cap1Sync_q[1:0], capturePinOne};
      cap2Sync_q <= {cap2Sync_q[1:0], capturePinTwo};
      extSync_q <= {extSync_q[1:0], externalClockPin};
      prescale_q <= prescale_q + 3'h1;
    end
  end

  // Control and compare registers
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrlOne_q <= `TMR_CTRL_RST;
      ctrlTwo_q <= `TMR_CTRL_RST;
      cmp1_q <= `TMR_CMP_RST;
      cmp2_q <= `TMR_CMP_RST;
      cmp1Armed_q <= 1'b1;
      cmp2Armed_q <= 1'b1;
    end else if (wrCtrl) begin
      case (ofs)
        `TMR_OFS_CTRL1: ctrlOne_q <= regWrData;
        `TMR_OFS_CTRL2: ctrlTwo_q <= regWrData;
        `TMR_OFS_CMP1H: begin
          cmp1_q[15:8] <= regWrData;
          cmp1Armed_q <= 1'b0;
        end
        `TMR_OFS_CMP1L: begin
          cmp1_q[7:0] <= regWrData;
          cmp1Armed_q <= 1'b1;
        end
        `TMR_OFS_CMP2H: begin
          cmp2_q[15:8] <= regWrData;
          cmp2Armed_q <= 1'b0;
        end
        `TMR_OFS_CMP2L: begin
          cmp2_q[7:0] <= regWrData;
          cmp2Armed_q <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // Counter: reset value, ticks, PWM period and one-pulse restart
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_q <= `TMR_CNT_RST;
    end else if (regWrite && ofs == `TMR_OFS_CNTL) begin
      count_q <= `TMR_CNT_RST;
    end else if (pwmPeriod || pulseStart) begin
      count_q <= `TMR_CNT_RST;
    end else if (run) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // Deep-stop capture arming, captured values
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      arm1_q <= 1'b0;
      arm2_q <= 1'b0;
      stopped_q <= 1'b0;
      cap1_q <= 16'h0000;
      cap2_q <= 16'h0000;
    end else begin
      stopped_q <= deepStop;
      if (deepStop && cap1Edge && !pwmMode && !onePulse) arm1_q <= 1'b1;
      else if (waking) arm1_q <= 1'b0;
      if (deepStop && cap2Edge) arm2_q <= 1'b1;
      else if (waking) arm2_q <= 1'b0;
      if (cap1Now) cap1_q <= count_q;
      else if (pulseStart) cap1_q <= `TMR_CNT_RST + 16'h0001;
      if (cap2Now) cap2_q <= count_q;
    end
  end

  // Flags: set wins over the two-step clear
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      flags_q <= 5'h00;
      flagsRead_q <= 1'b0;
    end else begin
      if (regRead && ofs == `TMR_OFS_FLAGS) flagsRead_q <= 1'b1;
      if (rdAny && flagsRead_q) begin
        case (ofs)
          `TMR_OFS_CAP1L: flags_q[4] <= 1'b0;
          `TMR_OFS_CMP1L: flags_q[3] <= 1'b0;
          `TMR_OFS_CNTL: flags_q[2] <= 1'b0;
          `TMR_OFS_CAP2L: flags_q[1] <= 1'b0;
          `TMR_OFS_CMP2L: flags_q[0] <= 1'b0;
          default: ;
        endcase
      end
      if (cap1Now || pwmPeriod || pulseStart) flags_q[4] <= 1'b1;
      if (match1 && !pwmMode && !onePulse) flags_q[3] <= 1'b1;
      if (overflow) flags_q[2] <= 1'b1;
      if (cap2Now) flags_q[1] <= 1'b1;
      if (match2 && !pwmMode) flags_q[0] <= 1'b1;
    end
  end

  // Output levels on compare pins
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pulseOut_q <= 1'b0;
      pin2Out_q <= 1'b0;
    end else begin
      if (pwmMode || onePulse) begin
        if (pwmPeriod || pulseStart) pulseOut_q <= ctrlOne_q[`TMR_C1_LEVEL2];
        else if (match1) pulseOut_q <= ctrlOne_q[`TMR_C1_LEVEL1];
      end else if (ctrlOne_q[`TMR_C1_FORCE1] || match1) begin
        pulseOut_q <= ctrlOne_q[`TMR_C1_LEVEL1];
      end
      if (!pwmMode && !onePulse && (ctrlOne_q[`TMR_C1_FORCE2] || match2))
        pin2Out_q <= ctrlOne_q[`TMR_C1_LEVEL2];
    end
  end

  // Registered outputs: pins, interrupt request, read data
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      comparePinOne <= 1'b0;
      comparePinOneEn <= 1'b0;
      comparePinTwo <= 1'b0;
      comparePinTwoEn <= 1'b0;
      timerIrq <= 1'b0;
      wakeIdle <= 1'b0;
      regRdData <= 8'h00;
    end else begin
      comparePinOne <= pulseOut_q;
      comparePinOneEn <= ctrlTwo_q[`TMR_C2_PIN1_EN];
      comparePinTwo <= pin2Out_q;
      comparePinTwoEn <= ctrlTwo_q[`TMR_C2_PIN2_EN];
      timerIrq <= ~globalIrqMask &
        ((ctrlOne_q[`TMR_C1_CAP_IE] & (flags_q[4] | flags_q[1])) |
         (ctrlOne_q[`TMR_C1_CMP_IE] & (flags_q[3] | flags_q[0])) |
         (ctrlOne_q[`TMR_C1_OVF_IE] & flags_q[2]));
      wakeIdle <= idleMode & ~deepStop & ~globalIrqMask &
        ((ctrlOne_q[`TMR_C1_CAP_IE] & (flags_q[4] | flags_q[1])) |
         (ctrlOne_q[`TMR_C1_CMP_IE] & (flags_q[3] | flags_q[0])) |
         (ctrlOne_q[`TMR_C1_OVF_IE] & flags_q[2]));
      if (regRead) begin
        case (ofs)
          `TMR_OFS_CTRL1: regRdData <= ctrlOne_q;
          `TMR_OFS_CTRL2: regRdData <= ctrlTwo_q;
          `TMR_OFS_FLAGS: regRdData <= {flags_q, 3'h0};
          `TMR_OFS_CAP1H: regRdData <= cap1_q[15:8];
          `TMR_OFS_CAP1L: regRdData <= cap1_q[7:0];
          `TMR_OFS_CMP1H: regRdData <= cmp1_q[15:8];
          `TMR_OFS_CMP1L: regRdData <= cmp1_q[7:0];
          `TMR_OFS_CMP2H: regRdData <= cmp2_q[15:8];
          `TMR_OFS_CMP2L: regRdData <= cmp2_q[7:0];
          `TMR_OFS_CNTH: regRdData <= count_q[15:8];
          `TMR_OFS_CNTL: regRdData <= count_q[7:0];
          `TMR_OFS_CAP2H: regRdData <= cap2_q[15:8];
          `TMR_OFS_CAP2L: regRdData <= cap2_q[7:0];
          default: regRdData <= 8'h00;
        endcase
      end else begin
        regRdData <= 8'h00;
      end
    end
  end

endmodule // tmr_timer16

`default_nettype wire

// ==== tmr_timer16_chk_asserts.sv ====
// Checker for the 16-bit timer control block: pin routing, forcing, irq.
// Bound to tmr_timer16; mirrors control writes seen on its register port.
`timescale 1ns/1ps
`default_nettype none
module tmr_timer16_chk #(
  parameter ADDR_W = 4
) (
  input wire clk_sys,
  input wire reset,
  input wire [ADDR_W-1:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regRdData,
  input wire globalIrqMask,
  input wire idleMode,
  input wire deepStop,
  input wire capturePinOne,
  input wire capturePinTwo,
  input wire externalClockPin,
  input wire timerIrq,
  input wire wakeIdle,
  input wire comparePinOne,
  input wire comparePinOneEn,
  input wire comparePinTwo,
  input wire comparePinTwoEn
);
  reg [7:0] ctlOne_q;
  reg [7:0] ctlTwo_q;
  // Shadow of both control registers
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctlOne_q <= 8'h00;
      ctlTwo_q <= 8'h00;
    end else if (regWrite) begin
      if (regAddr == 4'h0) ctlOne_q <= regWrData;
      if (regAddr == 4'h1) ctlTwo_q <= regWrData;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Control unchanged long enough for registered outputs to follow
  sequence s_settled;
    ($stable(ctlOne_q) && $stable(ctlTwo_q)) [*3];
  endsequence
  // Force bit and pin enable set, no pulse mode selected
  sequence s_force(f, en);
    s_settled ##0 (f && en && ctlTwo_q[5:4] == 2'h0);
  endsequence
  a_pin1_route: assert property (s_settled |-> comparePinOneEn == ctlTwo_q[7])
    else $error("pin one enable wrong");
  a_pin2_route: assert property (s_settled |-> comparePinTwoEn == ctlTwo_q[6])
    else $error("pin two enable wrong");
  a_force_one: assert property (s_force(ctlOne_q[3], ctlTwo_q[7])
    |-> comparePinOne == ctlOne_q[0]) else $error("pin one not forced");
  a_force_two: assert property (s_force(ctlOne_q[4], ctlTwo_q[6])
    |-> comparePinTwo == ctlOne_q[2]) else $error("pin two not forced");
  a_irq_mask: assert property (globalIrqMask && $past(globalIrqMask) |-> !timerIrq)
    else $error("irq while masked");
  a_irq_enable: assert property (s_settled ##0 ctlOne_q[7:5] == 3'h0 |-> !timerIrq)
    else $error("irq with enables clear");
  a_wake_idle: assert property (wakeIdle |-> timerIrq && $past(idleMode))
    else $error("wake without idle irq");
  a_stop_nowake: assert property (deepStop && $past(deepStop) |-> !wakeIdle)
    else $error("wake in deep stop");
  a_read_ctl: assert property (regRead && regAddr == 4'h1 |=> regRdData == $past(ctlTwo_q))
    else $error("control two readback wrong");
endmodule // tmr_timer16_chk
`default_nettype wire

// ==== tmr_timer16_tb.sv ====
// Self-checking bench for the 16-bit timer control block.
// Drives the register port at rising edges; pins come from tmr_pin_model.
`timescale 1ns/1ps
`default_nettype none
module tmr_timer16_tb;
  logic clk_sys, reset, regWrite, regRead, globalIrqMask, idleMode, deepStop;
  logic extRun, capLevelOne, capLevelTwo;
  logic [3:0] regAddr;
  logic [7:0] regWrData, d1, d2;
  logic [1:0] seen;
  logic [7:0] ctlTab [5];
  logic [7:0] expDiff [5];
  wire [7:0] regRdData;
  wire timerIrq, wakeIdle, comparePinOne, comparePinOneEn, comparePinTwo, comparePinTwoEn;
  wire capturePinOne, capturePinTwo, externalClockPin;
  int nErrors, testsRun, i;
  tmr_timer16 #(.ADDR_W(4)) u_dut (.clk_sys, .reset, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .globalIrqMask, .idleMode, .deepStop, .capturePinOne,
    .capturePinTwo, .externalClockPin, .timerIrq, .wakeIdle, .comparePinOne,
    .comparePinOneEn, .comparePinTwo, .comparePinTwoEn);
  tmr_pin_model u_pins (.clk_sys, .extRun, .capLevelOne, .capLevelTwo, .externalClockPin,
    .capturePinOne, .capturePinTwo);
  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 v = regRdData;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      nErrors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v & m, exp);
  endtask
  task automatic results;
    $display("Checks run %0d, mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {reset, regWrite, regRead, globalIrqMask, idleMode, deepStop} = 6'h20;
    {extRun, capLevelOne, capLevelTwo, regAddr, regWrData} = 15'h0;
    {nErrors, testsRun} = 0;
    ctlTab = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h0d};
    expDiff = '{8'h10, 8'h20, 8'h08, 8'h08, 8'h08};
    wt(3);
    reset <= 1'b0;
    rdchk(4'h2, 8'hff, 8'h00);
    rdchk(4'h9, 8'hff, 8'hff);
    rdchk(4'h0, 8'hff, 8'h00);
    rdchk(4'h1, 8'hff, 8'h00);
    rdchk(4'hf, 8'hff, 8'h00);
    extRun <= 1'b1;
    for (i = 0; i < 5; i++) begin
      wr(4'h1, ctlTab[i]);
      wt(8);
      rd(4'ha, d1);
      wt(62);
      rd(4'ha, d2);
      chk(d2 - d1, expDiff[i]);
    end
    extRun <= 1'b0;
    wr(4'h1, 8'h04);
    wr(4'h0, 8'h20);
    wr(4'ha, 8'h00);
    wt(20);
    rdchk(4'h2, 8'h20, 8'h20);
    chk({7'h0, timerIrq}, 8'h01);
    wt(1);
    idleMode <= 1'b1;
    wt(3);
    #1 chk({7'h0, wakeIdle}, 8'h01);
    wt(1);
    deepStop <= 1'b1;
    wt(3);
    rd(4'ha, d1);
    wt(30);
    rdchk(4'ha, 8'hff, d1);
    chk({7'h0, wakeIdle}, 8'h00);
    wt(1);
    deepStop <= 1'b0;
    idleMode <= 1'b0;
    globalIrqMask <= 1'b1;
    wt(3);
    #1 chk({7'h0, timerIrq}, 8'h00);
    wt(1);
    globalIrqMask <= 1'b0;
    rd(4'h2, d1);
    rd(4'ha, d1);
    rdchk(4'h2, 8'h20, 8'h00);
    wr(4'h1, 8'hc0);
    wr(4'h0, 8'h19);
    wt(3);
    #1 chk({6'h0, comparePinOne, comparePinTwo}, 8'h02);
    wr(4'h0, 8'h1c);
    wt(3);
    #1 chk({6'h0, comparePinOne, comparePinTwo}, 8'h01);
    chk({6'h0, comparePinOneEn, comparePinTwoEn}, 8'h03);
    wr(4'h0, 8'h82);
    wr(4'h1, 8'h00);
    capLevelOne <= 1'b1;
    capLevelTwo <= 1'b1;
    wt(8);
    rdchk(4'h2, 8'h90, 8'h80);
    chk({7'h0, timerIrq}, 8'h01);
    wt(1);
    capLevelTwo <= 1'b0;
    wt(8);
    rdchk(4'h2, 8'h10, 8'h10);
    rd(4'h2, d1);
    wr(4'h1, 8'h94);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h08);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h20);
    rd(4'h4, d1);
    wr(4'h0, 8'h04);
    wr(4'ha, 8'h00);
    seen = 2'h0;
    for (i = 0; i < 200; i++) begin
      wt(1);
      #1 seen = seen | (comparePinOne ? 2'h2 : 2'h1);
    end
    chk({6'h0, seen}, 8'h03);
    rdchk(4'h2, 8'hc8, 8'h80);
    wr(4'h1, 8'ha4);
    capLevelOne <= 1'b0;
    wt(7);
    #1 chk({7'h0, comparePinOne}, 8'h01);
    rdchk(4'h4, 8'hff, 8'hfd);
    wt(40);
    #1 chk({7'h0, comparePinOne}, 8'h00);
    results;
  end
  // Watchdog against a hung run
  initial begin
    wt(5000);
    nErrors++;
    results;
  end
endmodule // tmr_timer16_tb
bind tmr_timer16 tmr_timer16_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_sys, .reset, .regAddr,
  .regWrData, .regWrite, .regRead, .regRdData, .globalIrqMask, .idleMode, .deepStop,
  .capturePinOne, .capturePinTwo, .externalClockPin, .timerIrq, .wakeIdle, .comparePinOne,
  .comparePinOneEn, .comparePinTwo, .comparePinTwoEn);
`default_nettype wire
